/* logic/acc_map.svh */
// Notes on behaviour
// - With auto-trigger enabled, each rising edge of the selected source starts a conversion unless one is already running.
// - Conversion-done flag sets when a conversion ends and result bytes are loaded.
// - Interrupt request only while irq enable, global enable and done flag are all one.
// - Done flag clears automatically when the processor takes the converter vector.
// - Writing one to the done flag clears it; writing zero leaves it.
// - Divider code 000/001 gives 2; 010..111 give 4, 8, 16, 32, 64, 128.
// - Right-justified: high byte holds bits 9:8 in 1:0, low byte bits 7:0.
// - Left-justified: high byte holds bits 9:2, low byte bits 1:0 in 7:6.
// - After a low byte read, both bytes freeze until the high byte is read.
// - Trigger source has no effect while auto-trigger enable is zero.
// - Source codes: free run, comparator, ext int 0, t0 cmp A, t0 ovf, t1 cmp B, t1 ovf, t1 cap.
// - Trigger is a rising flag edge; switching from a clear source to a set source counts as an edge.
// - Switching to the free-running code never makes a trigger event.
// - Each set input-disable bit turns off its pin buffer and forces its port bit zero.
// - Enable one powers the converter; zero turns it off and aborts a conversion.
// - Start bit begins a conversion, reads one until done; first takes 25 clocks, else 13.
// - Reference and channel changes during a conversion apply only after it completes.
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

`define ACC_IDX_RESULT_LOW 8'h78
`define ACC_IDX_RESULT_HIGH 8'h79
`define ACC_IDX_CONTROL_A 8'h7a
`define ACC_IDX_CONTROL_B 8'h7b
`define ACC_IDX_MUX_SELECT 8'h7c
`define ACC_IDX_INPUT_DISABLE 8'h7e

`define ACC_A_ENABLE 7
`define ACC_A_START 6
`define ACC_A_AUTO 5
`define ACC_A_FLAG 4
`define ACC_A_IRQ_EN 3
`define ACC_M_LEFT 5
`define ACC_B_COMP_MUX 6

`define ACC_RESET_BYTE 8'h00
`define ACC_RESET_RESULT 10'h000

`define ACC_NORMAL_CYCLES 5'd13
`define ACC_FIRST_CYCLES 5'd25

`define ACC_RESP_OKAY 2'b00
`define ACC_RESP_SLVERR 2'b10

`endif

/* logic/acc_pkg.sv */
package acc_pkg;
    typedef enum logic [1:0] {
        acc_idle = 2'b01,
        acc_busy = 2'b10
    } acc_state_type;

    typedef logic [2:0] acc_divider_type;

    // Codes 000 and 001 both divide by two
    function automatic logic [7:0] divisor(input acc_divider_type code);
        logic [7:0] result;
        result = 8'h02;
        if (code > 3'h1) begin
            result = 8'h01 << code;
        end
        return result;
    endfunction
endpackage

/* logic/acc_seq_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface acc_seq_if;
    logic enable;
    logic start;
    logic [2:0] divider_select;
    logic busy;
    logic done;
    logic core_clock;
    logic sample;

    modport ctrl (output enable, output start, output divider_select,
                  input busy, input done, input core_clock, input sample);
    modport seq (input enable, input start, input divider_select,
                 output busy, output done, output core_clock, output sample);
endinterface
`default_nettype wire

/* logic/acc_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
`include "acc_map.svh"
module acc_sequencer (
    input wire logic clock,
    input wire logic rstn,
    acc_seq_if.seq sq
);
    acc_pkg::acc_state_type state;
    logic [6:0] presc;
    logic [4:0] count;
    logic first_pend;

    wire [7:0] div_full = acc_pkg::divisor(sq.divider_select);
    wire [7:0] div_last = div_full - 8'h01;
    wire [6:0] limit = div_last[6:0];
    wire tick = (presc == limit);
    wire [4:0] length = first_pend ? `ACC_FIRST_CYCLES : `ACC_NORMAL_CYCLES;
    wire last = tick && (count == length - 5'd1);
    wire [6:0] half = div_full[7:1];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            presc <= 7'h00;
        end else if (tick || state == acc_pkg::acc_idle) begin
            presc <= 7'h00;
        end else begin
            presc <= presc + 7'h01;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= acc_pkg::acc_idle;
            count <= 5'h00;
            sq.done <= 1'b0;
            sq.sample <= 1'b0;
        end else begin
            sq.done <= 1'b0;
            sq.sample <= 1'b0;
            case (state)
                acc_pkg::acc_idle: begin
                    count <= 5'h00;
                    if (sq.start && sq.enable) begin
                        state <= acc_pkg::acc_busy;
                        sq.sample <= 1'b1;
                    end
                end
                acc_pkg::acc_busy: begin
                    if (!sq.enable) begin
                        state <= acc_pkg::acc_idle;
                    end else if (last) begin
                        state <= acc_pkg::acc_idle;
                        sq.done <= 1'b1;
                    end else if (tick) begin
                        count <= count + 5'd1;
                    end
                end
                default: state <= acc_pkg::acc_idle;
            endcase
        end
    end

    // First conversion after power-up needs the long initialisation cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            first_pend <= 1'b1;
        end else if (!sq.enable) begin
            first_pend <= 1'b1;
        end else if (last) begin
            first_pend <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sq.core_clock <= 1'b0;
        end else begin
            sq.core_clock <= (state == acc_pkg::acc_busy) && (presc >= half);
        end
    end

    assign sq.busy = (state == acc_pkg::acc_busy);
endmodule // acc_sequencer
`default_nettype wire

/* logic/acc_top.sv */
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "acc_map.svh"
module acc_top #(
    parameter int ADDR_WIDTH = 12
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] trigger_flags,
    input wire logic cpu_global_irq_enable,
    input wire logic irq_ack,
    output logic conversion_irq,
    input wire logic [9:0] core_result,
    output logic core_power,
    output logic core_clock,
    output logic core_sample,
    output logic [3:0] core_channel,
    output logic [1:0] core_reference,
    output logic comparator_mux_enable,
    input wire logic [5:0] pin_digital_in,
    output logic [5:0] pin_buffer_off,
    output logic [5:0] port_in_value
);
    acc_seq_if seq ();

    acc_sequencer u_seq (
        .clock(clock),
        .rstn(rstn),
        .sq(seq.seq)
    );

    logic converter_enable, auto_trigger_enable, conversion_done_flag;
    logic conversion_irq_enable, left_justify, locked;
    logic [2:0] clock_divider_select, trigger_source_select, prev_src;
    logic [1:0] reference_select;
    logic [3:0] channel_select;
    logic [9:0] result_raw, core_meta, core_sync;
    logic [5:0] pin_meta, pin_sync;
    logic prev_sel, sample_d, done_d, sample_d2;

    function automatic logic [ADDR_WIDTH-1:0] addr_of(input logic [7:0] idx);
        return ADDR_WIDTH'({idx, 2'b00});
    endfunction

    // Write channel: both address and data taken in one cycle
    wire wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
    wire wr_fire = s_axi_awready;
    logic [ADDR_WIDTH-1:0] wr_addr;
    logic [7:0] wr_byte;
    logic wr_lane;
    wire wr_a = wr_fire && wr_lane && (wr_addr == addr_of(`ACC_IDX_CONTROL_A));
    wire wr_b = wr_fire && wr_lane && (wr_addr == addr_of(`ACC_IDX_CONTROL_B));
    wire wr_m = wr_fire && wr_lane && (wr_addr == addr_of(`ACC_IDX_MUX_SELECT));
    wire wr_d = wr_fire && wr_lane && (wr_addr == addr_of(`ACC_IDX_INPUT_DISABLE));
    wire wr_ro = (wr_addr == addr_of(`ACC_IDX_RESULT_LOW))
              || (wr_addr == addr_of(`ACC_IDX_RESULT_HIGH));
    wire wr_hit = (wr_addr == addr_of(`ACC_IDX_CONTROL_A))
               || (wr_addr == addr_of(`ACC_IDX_CONTROL_B))
               || (wr_addr == addr_of(`ACC_IDX_MUX_SELECT))
               || (wr_addr == addr_of(`ACC_IDX_INPUT_DISABLE)) || wr_ro;

    // Read channel
    wire rd_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
    wire rd_low = rd_take && (s_axi_araddr == addr_of(`ACC_IDX_RESULT_LOW));
    wire rd_high = rd_take && (s_axi_araddr == addr_of(`ACC_IDX_RESULT_HIGH));

    // Trigger selection and edge detection
    wire sel_flag = (trigger_source_select == 3'h0) ? conversion_done_flag
                  : trigger_flags[trigger_source_select];
    wire to_free = (trigger_source_select == 3'h0) && (prev_src != 3'h0);
    wire trig_edge = sel_flag && !prev_sel && !to_free;
    wire trig_start = auto_trigger_enable && converter_enable && trig_edge
                    && !seq.busy;
    wire sw_start = wr_a && wr_byte[`ACC_A_START] && wr_byte[`ACC_A_ENABLE];
    wire start_req = sw_start || trig_start;
    wire next_enable = wr_a ? wr_byte[`ACC_A_ENABLE] : converter_enable;
    wire next_irq_en = wr_a ? wr_byte[`ACC_A_IRQ_EN] : conversion_irq_enable;
    wire flag_clear = irq_ack || (wr_a && wr_byte[`ACC_A_FLAG]);
    // A completion in the clearing cycle still sets the flag
    wire next_flag = seq.done || (conversion_done_flag && !flag_clear);

    // Start written together with enable must see the new enable
    assign seq.enable = next_enable;
    assign seq.start = start_req;
    assign seq.divider_select = clock_divider_select;

    wire [7:0] low_byte = left_justify ? {result_raw[1:0], 6'h00}
                        : result_raw[7:0];
    wire [7:0] high_byte = left_justify ? result_raw[9:2]
                         : {6'h00, result_raw[9:8]};
    wire [7:0] ctrl_a = {converter_enable, seq.busy || start_req, auto_trigger_enable,
                         conversion_done_flag, conversion_irq_enable, clock_divider_select};
    wire [7:0] ctrl_b = {1'b0, comparator_mux_enable, 3'h0, trigger_source_select};
    wire [7:0] mux_sel = {reference_select, left_justify, 1'b0, channel_select};
    wire [7:0] dis_reg = {2'b00, pin_buffer_off};
    wire rd_hit_a = s_axi_araddr == addr_of(`ACC_IDX_CONTROL_A);
    wire rd_hit_b = s_axi_araddr == addr_of(`ACC_IDX_CONTROL_B);
    wire rd_hit_m = s_axi_araddr == addr_of(`ACC_IDX_MUX_SELECT);
    wire rd_hit_d = s_axi_araddr == addr_of(`ACC_IDX_INPUT_DISABLE);
    wire rd_hit_l = s_axi_araddr == addr_of(`ACC_IDX_RESULT_LOW);
    wire rd_hit_h = s_axi_araddr == addr_of(`ACC_IDX_RESULT_HIGH);
    wire rd_hit = rd_hit_a || rd_hit_b || rd_hit_m || rd_hit_d || rd_hit_l || rd_hit_h;
    wire [7:0] rd_byte = rd_hit_a ? ctrl_a
                       : rd_hit_b ? ctrl_b
                       : rd_hit_m ? mux_sel
                       : rd_hit_d ? dis_reg
                       : rd_hit_l ? low_byte
                       : rd_hit_h ? high_byte : 8'h00;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            wr_addr <= '0;
            wr_byte <= `ACC_RESET_BYTE;
            wr_lane <= 1'b0;
        end else begin
            s_axi_awready <= wr_take;
            s_axi_wready <= wr_take;
            if (wr_take) begin
                wr_addr <= s_axi_awaddr;
                wr_byte <= s_axi_wdata[7:0];
                wr_lane <= s_axi_wstrb[0];
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ACC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ACC_RESP_OKAY;
        end else begin
            s_axi_arready <= rd_take;
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h00_0000, rd_byte};
                s_axi_rresp <= rd_hit ? `ACC_RESP_OKAY : `ACC_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            converter_enable <= 1'b0;
            auto_trigger_enable <= 1'b0;
            conversion_irq_enable <= 1'b0;
            clock_divider_select <= 3'h0;
        end else if (wr_a) begin
            converter_enable <= wr_byte[`ACC_A_ENABLE];
            auto_trigger_enable <= wr_byte[`ACC_A_AUTO];
            conversion_irq_enable <= wr_byte[`ACC_A_IRQ_EN];
            clock_divider_select <= wr_byte[2:0];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            trigger_source_select <= 3'h0;
            comparator_mux_enable <= 1'b0;
            reference_select <= 2'h0;
            left_justify <= 1'b0;
            channel_select <= 4'h0;
            pin_buffer_off <= 6'h00;
        end else begin
            if (wr_b) begin
                trigger_source_select <= wr_byte[2:0];
                comparator_mux_enable <= wr_byte[`ACC_B_COMP_MUX];
            end
            if (wr_m) begin
                reference_select <= wr_byte[7:6];
                left_justify <= wr_byte[`ACC_M_LEFT];
                channel_select <= wr_byte[3:0];
            end
            if (wr_d) begin
                pin_buffer_off <= wr_byte[5:0];
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            conversion_done_flag <= 1'b0;
            conversion_irq <= 1'b0;
            prev_sel <= 1'b0;
            prev_src <= 3'h0;
        end else begin
            conversion_done_flag <= next_flag;
            conversion_irq <= next_flag && next_irq_en && cpu_global_irq_enable;
            prev_sel <= sel_flag;
            prev_src <= trigger_source_select;
        end
    end

    // Result update and low-then-high lock
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            result_raw <= `ACC_RESET_RESULT;
            locked <= 1'b0;
        end else begin
            if (seq.done && !locked) begin
                result_raw <= core_sync;
            end
            if (rd_high) begin
                locked <= 1'b0;
            end else if (rd_low) begin
                locked <= 1'b1;
            end
        end
    end

    // Analog core and pins are outside this clock; two stages each
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            core_meta <= `ACC_RESET_RESULT;
            core_sync <= `ACC_RESET_RESULT;
            pin_meta <= 6'h00;
            pin_sync <= 6'h00;
            port_in_value <= 6'h00;
        end else begin
            core_meta <= core_result;
            core_sync <= core_meta;
            pin_meta <= pin_digital_in;
            pin_sync <= pin_meta;
            port_in_value <= pin_sync & ~pin_buffer_off;
        end
    end

    // Mux settings only follow software while idle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            core_channel <= 4'h0;
            core_reference <= 2'h0;
            core_power <= 1'b0;
            core_clock <= 1'b0;
            core_sample <= 1'b0;
        end else begin
            if (!seq.busy) begin
                core_channel <= channel_select;
                core_reference <= reference_select;
            end
            core_power <= converter_enable;
            core_clock <= seq.core_clock;
            core_sample <= seq.sample;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sample_d <= 1'b0;
            sample_d2 <= 1'b0;
            done_d <= 1'b0;
        end else begin
            sample_d <= start_req && next_enable && !seq.busy;
            sample_d2 <= sample_d;
            done_d <= seq.done;
        end
    end

    property p_done_sets_flag;
        @(posedge clock) disable iff (!rstn) seq.done |=> conversion_done_flag;
    endproperty
    a_done_sets_flag: assert property (p_done_sets_flag) else $error("flag not set");

    property p_irq_gate;
        @(posedge clock) disable iff (!rstn)
            conversion_irq |-> conversion_done_flag && conversion_irq_enable;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without flag");

    property p_ack_clears;
        @(posedge clock) disable iff (!rstn) irq_ack && !seq.done |=> !conversion_done_flag;
    endproperty
    a_ack_clears: assert property (p_ack_clears) else $error("ack kept flag");

    property p_write_clears;
        @(posedge clock) disable iff (!rstn)
            wr_a && wr_byte[`ACC_A_FLAG] && !seq.done |=> !conversion_done_flag;
    endproperty
    a_write_clears: assert property (p_write_clears) else $error("w1c failed");

    property p_lock_holds;
        @(posedge clock) disable iff (!rstn) locked && !rd_high |=> $stable(result_raw);
    endproperty
    a_lock_holds: assert property (p_lock_holds) else $error("locked result moved");

    property p_no_auto;
        @(posedge clock) disable iff (!rstn) !auto_trigger_enable |-> start_req == sw_start;
    endproperty
    a_no_auto: assert property (p_no_auto) else $error("trigger without auto");

    property p_free_switch;
        @(posedge clock) disable iff (!rstn) to_free |-> !trig_start;
    endproperty
    a_free_switch: assert property (p_free_switch) else $error("free switch trigger");

    property p_abort;
        @(posedge clock) disable iff (!rstn) !seq.enable |=> !seq.busy;
    endproperty
    a_abort: assert property (p_abort) else $error("busy while off");

    property p_buffer_off;
        @(posedge clock) disable iff (!rstn)
            (port_in_value & $past(pin_buffer_off)) == 6'h00;
    endproperty
    a_buffer_off: assert property (p_buffer_off) else $error("disabled pin reads one");

    property p_start_runs;
        @(posedge clock) disable iff (!rstn)
            sample_d |-> seq.busy ##0 (seq.busy || done_d) [*8];
    endproperty
    a_start_runs: assert property (p_start_runs) else $error("start lost");

    property p_conv_min;
        @(posedge clock) disable iff (!rstn) sample_d2 |-> !seq.done [*8];
    endproperty
    a_conv_min: assert property (p_conv_min) else $error("conversion too short");
endmodule // acc_top
`default_nettype wire

/* verification/acc_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module acc_core_model (
    input wire logic clock,
    input wire logic rstn,
    input wire logic core_power,
    input wire logic core_sample,
    input wire logic [9:0] sample_value,
    output logic [9:0] core_result
);
    // Unpowered core gives no stable code, so the lines keep toggling
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            core_result <= 10'h155;
        end else if (!core_power) begin
            core_result <= ~core_result;
        end else if (core_sample) begin
            core_result <= sample_value;
        end
    end
endmodule // acc_core_model
`default_nettype wire

/* verification/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic gie = 1'b0, ack = 1'b0;
    logic [7:0] trig = 8'h00;
    logic [5:0] pins = 6'h00, dis, buf_off, port_in;
    logic [9:0] val = 10'h000, old, res;
    logic awready, wready, bvalid, arready, rvalid, irq, power, csample, cmux;
    logic [1:0] bresp, rresp, cref;
    logic [3:0] chan;
    logic [31:0] rdata;
    logic [21:0] notes[$];
    logic [21:0] note;
    int seed, err_total = 0, checks_done = 0;

    acc_top acc_top_i (.clock(clock), .rstn(rstn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .trigger_flags(trig), .cpu_global_irq_enable(gie),
        .irq_ack(ack), .conversion_irq(irq), .core_result(res), .core_power(power),
        .core_clock(), .core_sample(csample), .core_channel(chan), .core_reference(cref),
        .comparator_mux_enable(cmux), .pin_digital_in(pins), .pin_buffer_off(buf_off),
        .port_in_value(port_in));
    acc_core_model acc_core_model_i (.clock(clock), .rstn(rstn), .core_power(power),
        .core_sample(csample), .sample_value(val), .core_result(res));

    always #2.5 clock = ~clock;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [9:0] e, input logic [9:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = 2'b00);
        int n;
        n = 0;
        @(posedge clock);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (awready === 1'b1 && wready === 1'b1) begin
                awvalid <= 1'b0;
                wvalid <= 1'b0;
            end
        end while (bvalid !== 1'b1 && n < 200);
        bready <= 1'b0;
        if (n >= 200) begin
            err_total++;
            end_of_test();
        end
        chk("bresp", {8'h00, er}, {8'h00, bresp});
    endtask

    // Expected value is queued first; the monitor pairs it with the answer
    task automatic rd(input logic [11:0] a, input logic [9:0] e);
        int n;
        n = 0;
        notes.push_back({a, e});
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 200);
        rready <= 1'b0;
        if (n >= 200) begin
            err_total++;
            end_of_test();
        end
    endtask

    always @(posedge clock) begin
        if (rvalid === 1'b1 && rready === 1'b1 && notes.size() > 0) begin
            note = notes.pop_front();
            chk($sformatf("read %h", note[21:10]), note[9:0], {rresp, rdata[7:0]});
        end
    end

    initial begin
        seed = 73171;
        repeat (20) @(posedge clock);
        rstn <= 1'b1;
        rd(12'h1e0, 10'h000);
        rd(12'h1e4, 10'h000);
        rd(12'h1ec, 10'h000);
        rd(12'h1f8, 10'h000);
        rd(12'h1fc, 10'h200);
        wr(12'h1fc, 8'hff, 2'b10);
        $display("reset test done");
        val <= 10'($random(seed));
        wr(12'h1e8, 8'hc0);
        rd(12'h1e8, 10'h0c0);
        repeat (60) @(posedge clock);
        rd(12'h1e8, 10'h090);
        rd(12'h1e0, {2'b00, val[7:0]});
        rd(12'h1e4, {8'h00, val[9:8]});
        wr(12'h1f0, 8'h20);
        rd(12'h1e0, {2'b00, val[1:0], 6'h00});
        old = val;
        val <= 10'($random(seed));
        wr(12'h1e8, 8'hd0);
        repeat (40) @(posedge clock);
        rd(12'h1e8, 10'h090);
        rd(12'h1e4, {2'b00, old[9:2]});
        $display("conversion test done");
        gie <= 1'b1;
        wr(12'h1f0, 8'h00);
        val <= 10'($random(seed));
        wr(12'h1e8, 8'hd8);
        repeat (40) @(posedge clock);
        #1;
        chk("irq", 10'h001, {9'h000, irq});
        @(posedge clock);
        ack <= 1'b1;
        @(posedge clock);
        ack <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk("irq", 10'h000, {9'h000, irq});
        rd(12'h1e8, 10'h088);
        rd(12'h1e0, {2'b00, val[7:0]});
        $display("interrupt test done");
        for (int k = 1; k < 8; k++) begin
            trig <= 8'h00;
            wr(12'h1ec, 8'(k));
            wr(12'h1e8, 8'hb0);
            rd(12'h1e8, 10'h0a0);
            trig <= 8'h01 << k;
            repeat (40) @(posedge clock);
            rd(12'h1e8, 10'h0b0);
        end
        wr(12'h1e8, 8'hb0);
        wr(12'h1ec, 8'h06);
        wr(12'h1ec, 8'h07);
        repeat (40) @(posedge clock);
        rd(12'h1e8, 10'h0b0);
        wr(12'h1ec, 8'h06);
        wr(12'h1ec, 8'h40);
        chk("comparator_mux", 10'h001, {9'h000, cmux});
        rd(12'h1e8, 10'h0b0);
        wr(12'h1e8, 8'hd0);
        repeat (8) @(posedge clock);
        wr(12'h1e8, 8'h00);
        repeat (40) @(posedge clock);
        rd(12'h1e8, 10'h000);
        wr(12'h1e8, 8'hc7);
        wr(12'h1f0, 8'hc5);
        repeat (3000) @(posedge clock);
        #1;
        chk("core_mux", 10'h000, {4'h0, cref, chan});
        rd(12'h1e8, 10'h0c7);
        repeat (250) @(posedge clock);
        rd(12'h1e8, 10'h097);
        chk("core_mux", 10'h035, {4'h0, cref, chan});
        $display("trigger test done");
        for (int k = 0; k < 4; k++) begin
            pins <= 6'($random(seed));
            dis = 6'($random(seed));
            wr(12'h1f8, {2'b00, dis});
            repeat (4) @(posedge clock);
            #1;
            chk("port_in", {4'h0, pins & ~dis}, {4'h0, port_in});
            chk("buffer_off", {4'h0, dis}, {4'h0, buf_off});
            rd(12'h1f8, {4'h0, dis});
        end
        $display("input disable test done");
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
